//--- hw/eba_pkg.sv
// package: constants and carrier types for the external bus arbitration block
package eba_pkg;

  // ---------------------------------------------------------------
  // processor id encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] ID_SINGLE = 2'h0;
  localparam logic [1:0] ID_FIRST  = 2'h1;
  localparam logic [1:0] ID_SECOND = 2'h2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_DRIVE_MODE = 1'b0;
  localparam logic RST_LEVEL_LOW  = 1'b0;
  // registered outputs in reset: grants, wait ack, request lines and dma grants idle high
  localparam logic [15:0] RST_OUT = 16'hD035;

  // ---------------------------------------------------------------
  // dma channel numbers served by the two external pairs
  // ---------------------------------------------------------------
  localparam logic [3:0] DMA_CH_ONE = 4'h9;
  localparam logic [3:0] DMA_CH_TWO = 4'h8;

  // open-drain or driven pin: out, out enable
  typedef struct packed {
    logic o;
    logic oe;
  } eba_pin_t;

  // host side inputs, all active high; request and select after synchronisation
  typedef struct packed {
    logic host_bus_request;
    logic host_select;
    logic access_busy;
  } eba_host_t;

endpackage

//--- hw/eba_arbiter.sv
// module: external bus ownership arbiter with host, multiprocessor and dma handshakes
`timescale 1ns/1ps

// Contract
// [R1] host bus request is answered with host bus grant
// [R2] grant holds while request holds; released after request drops
// [R3] only the current bus master drives the host grant pin
// [R4] host asserts active-low select to access internal memory or registers
// [R5] wait ack deasserted while a host access cannot complete yet
// [R6] wait ack open drain after reset; drive-mode bit makes it driven
// [R7] wait ack driven only while select and host request are both asserted
// [R8] dma pair one serves channel 9, pair two channel 8; grant answers request
// [R9] drive only own request line by id; monitor others to arbitrate
// [R10] id 01 selects first line, 10 second, 00 single processor
// [R11] processor id stays constant except during reset
// [R12] bus slave core needing bus asserts core priority line, preempting dma
// [R13] core priority line is an open-drain output shared by both processors
// [R14] bus master indicator high only while owning the bus
// [R15] id 00 keeps bus master indicator high continuously
// [R16] three-statable pins float on suspend input or when bus slave; sdram pins stay driven in both cases
// [R17] on host grant float bus lines, keep driving sdram control
// [R18] host request beats all multiprocessor requests
// [R19] external access under suspend stalls until suspend released
// [R20] host grant waits for an external cycle in progress to finish
module eba_arbiter (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] processor_id,
  input  wire logic       host_bus_request_n,
  input  wire logic       host_select_n,
  input  wire logic       host_access_busy,
  input  wire logic       wait_ack_drive_mode,
  input  wire logic [1:0] multiproc_bus_request_n_in,
  input  wire logic       core_priority_line_n_in,
  input  wire logic       suspend_bus_input_n,
  input  wire logic       core_bus_need,
  input  wire logic       ext_cycle_active,
  input  wire logic       ext_access_req,
  input  wire logic       ext_dma_request_one_n,
  input  wire logic       ext_dma_request_two_n,
  input  wire logic       dma_ready_one,
  input  wire logic       dma_ready_two,
  output logic            host_bus_grant_n,
  output logic            host_bus_grant_oe,
  output logic            host_wait_ack,
  output logic            host_wait_ack_oe,
  output logic [1:0]      multiproc_bus_request_n_out,
  output logic [1:0]      multiproc_bus_request_oe,
  output logic            core_priority_line_n_out,
  output logic            core_priority_line_oe,
  output logic            bus_master_indicator,
  output logic            bus_pins_oe,
  output logic            sdram_pins_oe,
  output logic            ext_access_stall,
  output logic            ext_dma_grant_one_n,
  output logic            ext_dma_grant_two_n,
  output logic [3:0]      dma_grant_channel
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  assign async_in = {~host_bus_request_n, ~host_select_n, ~suspend_bus_input_n,
                     ~core_priority_line_n_in, ~multiproc_bus_request_n_in,
                     ~ext_dma_request_one_n, ~ext_dma_request_two_n};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  logic       hreq;
  logic       hsel;
  logic       susp;
  logic       cpa_any;
  logic [1:0] mreq;
  logic       dreq1;
  logic       dreq2;
  assign {hreq, hsel, susp, cpa_any, mreq, dreq1, dreq2} = sync2_r;

  // ---------------------------------------------------------------
  // processor id capture
  // ---------------------------------------------------------------
  logic [1:0] id_r;
  logic [1:0] id_nxt;
  logic       id_cap_r;
  logic       id_cap_nxt;

  // [R11] id caught once after reset release
  always_comb begin
    id_nxt     = id_cap_r ? id_r : processor_id;
    id_cap_nxt = 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      id_r     <= eba_pkg::ID_SINGLE;
      id_cap_r <= 1'b0;
    end else begin
      id_r     <= id_nxt;
      id_cap_r <= id_cap_nxt;
    end
  end

  // [R10] id decode
  logic single;
  logic own_idx;
  logic id_ok;
  assign single  = (id_r == eba_pkg::ID_SINGLE);
  assign own_idx = (id_r == eba_pkg::ID_SECOND);
  assign id_ok   = (id_r == eba_pkg::ID_FIRST) || (id_r == eba_pkg::ID_SECOND);

  // ---------------------------------------------------------------
  // ownership state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_SLAVE, ST_MASTER, ST_HOST_WAIT, ST_HOST} eba_state_t;
  eba_state_t st_r;
  eba_state_t st_nxt;
  logic       other_req;
  logic       own_req;

  assign other_req = id_ok && mreq[~own_idx];
  assign own_req   = core_bus_need || ext_access_req;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_SLAVE: begin
        // [R9] win when other line idle; id 01 wins a tie
        if (single || (own_req && !hreq && (!other_req || !own_idx)))
          st_nxt = ST_MASTER;
      end
      ST_MASTER: begin
        // [R18] host first
        if (hreq)
          st_nxt = ST_HOST_WAIT;
        else if (!single && other_req && !own_req && !ext_cycle_active)
          st_nxt = ST_SLAVE;
      end
      ST_HOST_WAIT: begin
        // [R20] finish current cycle
        if (!hreq)
          st_nxt = ST_MASTER;
        else if (!ext_cycle_active)
          st_nxt = ST_HOST;
      end
      ST_HOST: begin
        // [R2] hold until request withdrawn
        if (!hreq)
          st_nxt = ST_MASTER;
      end
      default: st_nxt = ST_SLAVE;
    endcase
  end

  // ---------------------------------------------------------------
  // output next values
  // ---------------------------------------------------------------
  logic [15:0] out_nxt;
  logic [15:0] out_r;
  logic        master_nxt;
  logic        own_bus;
  logic        wa_en;

  always_comb begin
    master_nxt = (st_nxt != ST_SLAVE);
    own_bus    = master_nxt && (st_nxt != ST_HOST);
    // [R7] only with select and host request
    wa_en      = hsel && hreq;
    out_nxt    = '0;
    // [R1] grant active low; [R3] driven only by master
    out_nxt[0] = !(st_nxt == ST_HOST);
    out_nxt[1] = master_nxt;
    // [R5] ready low while busy; [R6] open drain unless drive mode
    out_nxt[2] = !host_access_busy;
    out_nxt[3] = wa_en && (wait_ack_drive_mode || host_access_busy);
    // [R9] drive only own request line
    out_nxt[4] = !(id_ok && !own_idx && own_req);
    out_nxt[5] = !(id_ok && own_idx && own_req);
    out_nxt[6] = id_ok && !own_idx;
    out_nxt[7] = id_ok && own_idx;
    // [R12] [R13] slave core pulls priority line low only
    out_nxt[8] = 1'b0;
    out_nxt[9] = !single && !master_nxt && core_bus_need;
    // [R14] [R15] master indicator
    out_nxt[10] = single || own_bus;
    // [R16] [R17] float when suspended, slave or host owned; sdram stays
    out_nxt[11] = own_bus && !susp;
    out_nxt[12] = 1'b1;
    // [R19] stall access under suspend
    out_nxt[13] = ext_access_req && (susp || !own_bus);
    // [R8] grants answer own request; priority line preempts dma
    out_nxt[14] = !(dreq1 && dma_ready_one && !cpa_any && out_nxt[11]);
    out_nxt[15] = !(dreq2 && dma_ready_two && !cpa_any && out_nxt[11]);
  end

  logic [3:0] ch_nxt;
  logic [3:0] ch_r;
  assign ch_nxt = !out_nxt[14] ? eba_pkg::DMA_CH_ONE :
                  !out_nxt[15] ? eba_pkg::DMA_CH_TWO : 4'h0;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r  <= ST_SLAVE;
      out_r <= eba_pkg::RST_OUT;
      ch_r  <= 4'h0;
    end else begin
      st_r  <= st_nxt;
      out_r <= out_nxt;
      ch_r  <= ch_nxt;
    end
  end

  assign host_bus_grant_n            = out_r[0];
  assign host_bus_grant_oe           = out_r[1];
  assign host_wait_ack               = out_r[2];
  assign host_wait_ack_oe            = out_r[3];
  assign multiproc_bus_request_n_out = out_r[5:4];
  assign multiproc_bus_request_oe    = out_r[7:6];
  assign core_priority_line_n_out    = out_r[8];
  assign core_priority_line_oe       = out_r[9];
  assign bus_master_indicator        = out_r[10];
  assign bus_pins_oe                 = out_r[11];
  assign sdram_pins_oe               = out_r[12];
  assign ext_access_stall            = out_r[13];
  assign ext_dma_grant_one_n         = out_r[14];
  assign ext_dma_grant_two_n         = out_r[15];
  assign dma_grant_channel           = ch_r;

endmodule

//--- dv/eba_arbiter_checker.sv
// checker: assertions on the external bus arbiter ports
`timescale 1ns/1ps
module eba_arbiter_checker (
  input logic       mclk,
  input logic       sys_rst,
  input logic [1:0] processor_id,
  input logic       host_bus_request_n,
  input logic       host_select_n,
  input logic       host_access_busy,
  input logic       wait_ack_drive_mode,
  input logic       ext_cycle_active,
  input logic       suspend_bus_input_n,
  input logic       ext_dma_request_one_n,
  input logic       host_bus_grant_n,
  input logic       host_wait_ack,
  input logic       host_wait_ack_oe,
  input logic [1:0] multiproc_bus_request_oe,
  input logic       bus_master_indicator,
  input logic       bus_pins_oe,
  input logic       ext_dma_grant_one_n
);
  wire       req    = !host_bus_request_n;
  wire       sel    = !host_select_n;
  wire       single = processor_id == eba_pkg::ID_SINGLE;
  wire [1:0] own    = processor_id == eba_pkg::ID_FIRST ? 2'h1 :
                      processor_id == eba_pkg::ID_SECOND ? 2'h2 : 2'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_GRANT_GIVEN: assert property (
    (single && req && !ext_cycle_active)[*6] |-> !host_bus_grant_n) else $error("no grant");
  AST_GRANT_HELD: assert property (
    req && !host_bus_grant_n |=> !host_bus_grant_n) else $error("grant dropped");
  AST_OWN_LINE: assert property (
    (multiproc_bus_request_oe & ~own) == 2'h0) else $error("foreign line driven");
  AST_SINGLE_MASTER: assert property (
    (single && !req)[*6] |-> bus_master_indicator) else $error("single not master");
  AST_ACK_RELEASED: assert property (
    (!(sel && req))[*4] |-> !host_wait_ack_oe) else $error("wait ack driven");
  AST_ACK_WAIT: assert property (
    (sel && req && host_access_busy)[*4] |-> host_wait_ack_oe && !host_wait_ack) else $error("no wait");
  AST_ACK_OPEN_DRAIN: assert property (
    (sel && req && !host_access_busy && !wait_ack_drive_mode)[*4] |-> !host_wait_ack_oe)
    else $error("wait ack not open drain");
  AST_DMA_OWN: assert property (
    ext_dma_request_one_n[*5] |-> ext_dma_grant_one_n) else $error("dma grant unasked");
  AST_SUSPEND_FLOAT: assert property (
    (!suspend_bus_input_n)[*4] |-> !bus_pins_oe) else $error("pins driven in suspend");
endmodule

bind eba_arbiter eba_arbiter_checker CHK (.*);

//--- dv/eba_host_model.sv
// partner model: host processor driving bus request and select
`timescale 1ns/1ps
module eba_host_model (
  input  logic mclk,
  output logic host_bus_request_n,
  output logic host_select_n
);
  initial begin
    host_bus_request_n = 1'h1;
    host_select_n      = 1'h1;
  end
  // active-low select and request, changed just after an edge
  task automatic drive(input logic sel, input logic req);
    @(posedge mclk);
    host_select_n      <= ~sel;
    host_bus_request_n <= ~req;
  endtask
endmodule

//--- dv/eba_arbiter_tb.sv
// testbench: self-checking bench for the external bus arbiter
`timescale 1ns/1ps
module eba_arbiter_tb;
  logic       mclk = 1'h0, sys_rst = 1'h1, host_access_busy = 1'h0, wait_ack_drive_mode = 1'h0;
  logic       suspend_bus_input_n = 1'h1, core_bus_need = 1'h0, ext_cycle_active = 1'h0;
  logic       ext_access_req = 1'h0, ext_dma_request_one_n = 1'h1, ext_dma_request_two_n = 1'h1;
  logic       dma_ready_one = 1'h1, dma_ready_two = 1'h1, peer_cpa_n = 1'h1, host_bus_request_n;
  logic       host_select_n, host_bus_grant_n, host_bus_grant_oe, host_wait_ack, host_wait_ack_oe;
  logic       core_priority_line_n_out, core_priority_line_oe, bus_master_indicator, bus_pins_oe;
  logic       sdram_pins_oe, ext_access_stall, ext_dma_grant_one_n, ext_dma_grant_two_n;
  logic       core_priority_line_n_in;
  logic [1:0] processor_id = 2'h0, peer_mp_n = 2'h3, multiproc_bus_request_n_out;
  logic [1:0] multiproc_bus_request_oe, multiproc_bus_request_n_in;
  logic [3:0] dma_grant_channel;
  // rows: sel, req, busy, drive mode, expected oe, expected ack
  logic [5:0] rows [5] = '{6'h1D, 6'h2D, 6'h3A, 6'h31, 6'h37};
  int         bad_count = 0, check_count = 0;
  // wired-and lines with pull-ups, shared with the other processor
  assign multiproc_bus_request_n_in = ~(multiproc_bus_request_oe & ~multiproc_bus_request_n_out)
                                      & peer_mp_n;
  assign core_priority_line_n_in = ~(core_priority_line_oe & ~core_priority_line_n_out) & peer_cpa_n;
  always #2.5 mclk = ~mclk;
  eba_host_model PEER (.mclk, .host_bus_request_n, .host_select_n);
  eba_arbiter DUT (.*);

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic await_grant(input logic v);
    for (int i = 0; i < 30 && host_bus_grant_n !== v; i++) @(posedge mclk);
    #1 chk({3'h0, host_bus_grant_n}, {3'h0, v});
    if (host_bus_grant_n !== v) wrap_up();
  endtask
  task automatic do_reset(input logic [1:0] id);
    @(posedge mclk);
    sys_rst <= 1'h1;
    processor_id <= id;
    repeat (10) @(posedge mclk);
    #1 chk({host_bus_grant_n, host_wait_ack_oe, bus_master_indicator, sdram_pins_oe}, 4'h9);
    @(posedge mclk) sys_rst <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    do_reset(eba_pkg::ID_SINGLE);
    foreach (rows[i]) begin
      PEER.drive(rows[i][5], rows[i][4]);
      host_access_busy <= rows[i][3];
      wait_ack_drive_mode <= rows[i][2];
      repeat (5) @(posedge mclk);
      #1 chk({2'h0, host_wait_ack_oe, host_wait_ack | ~rows[i][1]}, {2'h0, rows[i][1:0]});
    end
    $display("wait ack rows done");
    PEER.drive(1'h0, 1'h0);
    host_access_busy <= 1'h0;
    ext_cycle_active <= 1'h1;
    repeat (6) @(posedge mclk);
    PEER.drive(1'h0, 1'h1);
    repeat (8) @(posedge mclk);
    #1 chk({3'h0, host_bus_grant_n}, 4'h1);
    @(posedge mclk) ext_cycle_active <= 1'h0;
    await_grant(1'h0);
    chk({2'h0, bus_pins_oe, sdram_pins_oe}, 4'h1);
    repeat (6) @(posedge mclk);
    #1 chk({3'h0, host_bus_grant_n}, 4'h0);
    PEER.drive(1'h0, 1'h0);
    await_grant(1'h1);
    $display("host grant test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) ext_dma_request_one_n <= k[0];
      ext_dma_request_two_n <= ~k[0];
      repeat (4) @(posedge mclk);
      #1 chk(dma_grant_channel, k ? eba_pkg::DMA_CH_TWO : eba_pkg::DMA_CH_ONE);
      chk({2'h0, ext_dma_grant_two_n, ext_dma_grant_one_n}, k ? 4'h1 : 4'h2);
    end
    @(posedge mclk) peer_cpa_n <= 1'h0;
    repeat (4) @(posedge mclk);
    #1 chk({2'h0, ext_dma_grant_two_n, ext_dma_grant_one_n}, 4'h3);
    @(posedge mclk) peer_cpa_n <= 1'h1;
    ext_dma_request_two_n <= 1'h1;
    $display("dma test done");
    @(posedge mclk) suspend_bus_input_n <= 1'h0;
    ext_access_req <= 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk({2'h0, bus_pins_oe, ext_access_stall}, 4'h1);
    @(posedge mclk) suspend_bus_input_n <= 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk({2'h0, bus_pins_oe, ext_access_stall}, 4'h2);
    @(posedge mclk) ext_access_req <= 1'h0;
    $display("suspend test done");
    do_reset(eba_pkg::ID_FIRST);
    @(posedge mclk) core_bus_need <= 1'h1;
    repeat (6) @(posedge mclk);
    #1 chk({bus_master_indicator, multiproc_bus_request_oe, multiproc_bus_request_n_out[0]},
           4'hA);
    @(posedge mclk) core_bus_need <= 1'h0;
    peer_mp_n <= 2'h1;
    repeat (6) @(posedge mclk);
    #1 chk({bus_master_indicator, bus_pins_oe, host_bus_grant_oe, 1'h0}, 4'h0);
    @(posedge mclk) peer_mp_n <= 2'h2;
    do_reset(eba_pkg::ID_SECOND);
    @(posedge mclk) core_bus_need <= 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk({multiproc_bus_request_oe, core_priority_line_oe, bus_master_indicator}, 4'hA);
    $display("multiprocessor test done");
    wrap_up();
  end
endmodule
